// ---- hdl/dpcpa_consts.vh ----
// constants for the data plane configuration and port access register bank
// assumes inclusion by dpcpa_top.v and dpcpa_port_status.v
`ifndef DPCPA_CONSTS_VH
`define DPCPA_CONSTS_VH

// --------------------------------------------------------------------------
// register offsets (word index on the control register bus)
// --------------------------------------------------------------------------
`define DPCPA_OFF_REVISION  3'h0
`define DPCPA_OFF_CONTROL   3'h1
`define DPCPA_OFF_STATUS    3'h2
`define DPCPA_OFF_SETTINGS  3'h3
`define DPCPA_OFF_COMMAND   3'h4
`define DPCPA_OFF_LOW_WORD  3'h5
`define DPCPA_OFF_HIGH_WORD 3'h6

// --------------------------------------------------------------------------
// data_plane_settings fields and reset
// --------------------------------------------------------------------------
`define DPCPA_SET_SEG_HI     25
`define DPCPA_SET_SEG_LO     24
`define DPCPA_SET_HUNGRY_HI  23
`define DPCPA_SET_HUNGRY_LO  16
`define DPCPA_SET_STARVE_HI  15
`define DPCPA_SET_STARVE_LO  8
`define DPCPA_SET_WMARK_HI   7
`define DPCPA_SET_WMARK_LO   0
`define DPCPA_SET_MASK       32'h03ffffff
`define DPCPA_SET_RESET      32'h0080f00a
`define DPCPA_SEG_BASE_BYTES 10'h040

// --------------------------------------------------------------------------
// port_indirect_command fields and reset
// --------------------------------------------------------------------------
`define DPCPA_CMD_DIR        31
`define DPCPA_CMD_PHY        30
`define DPCPA_CMD_BUSY       29
`define DPCPA_CMD_OFF_HI     12
`define DPCPA_CMD_OFF_LO     3
`define DPCPA_CMD_PORT_HI    2
`define DPCPA_CMD_PORT_LO    0
`define DPCPA_CMD_RESET      32'h00000000
`define DPCPA_WORD_RESET     32'h00000000

// --------------------------------------------------------------------------
// control register fields and reset
// --------------------------------------------------------------------------
`define DPCPA_CTL_FC_HI      23
`define DPCPA_CTL_FC_LO      16
`define DPCPA_CTL_FC_MAX     8'hbf
`define DPCPA_CTL_SINK_EN    11
`define DPCPA_CTL_SRC_EN     10
`define DPCPA_CTL_ALIGN      9
`define DPCPA_CTL_DISCARD    8
`define DPCPA_CTL_CORE_RST   2
`define DPCPA_CTL_MASK       32'h00ff0fff
`define DPCPA_CTL_RESET      32'h00800000

// --------------------------------------------------------------------------
// status register layout
// --------------------------------------------------------------------------
`define DPCPA_STS_SPI_HI     31
`define DPCPA_STS_SPI_LO     21
`define DPCPA_STS_ING_HI     16
`define DPCPA_STS_ING_LO     9
`define DPCPA_STS_EGR_HI     8
`define DPCPA_STS_EGR_LO     1
`define DPCPA_STS_RESET      32'h00000000

// --------------------------------------------------------------------------
// link status codes per port
// --------------------------------------------------------------------------
`define DPCPA_ST_STARVING    2'h0
`define DPCPA_ST_HUNGRY      2'h1
`define DPCPA_ST_SATISFIED   2'h2

`endif

// ---- hdl/dpcpa_port_status.v ----
// per-port ingress status: starving / hungry / satisfied and tx start
// assumes free space and fill level synchronous to clk, counted in 64-bit words
`include "dpcpa_consts.vh"
`default_nettype none

module dpcpa_port_status (
  input  wire        clk,
  input  wire        reset,
  input  wire        ce,
  input  wire [10:0] free_words,
  input  wire [10:0] fill_words,
  input  wire [7:0]  hungry_thr,
  input  wire [7:0]  starve_thr,
  input  wire [7:0]  tx_wmark,
  input  wire        passthrough,
  output reg  [1:0]  link_status,
  output reg         tx_start
);

  reg [1:0] status_next;

  always @*
  begin
    if (free_words >= {3'h0, starve_thr})
      status_next = `DPCPA_ST_STARVING; // [RULE4] [RULE5]
    else if (free_words >= {3'h0, hungry_thr})
      status_next = `DPCPA_ST_HUNGRY; // [RULE3]
    else
      status_next = `DPCPA_ST_SATISFIED;
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      link_status <= `DPCPA_ST_SATISFIED;
      tx_start    <= 1'b0;
    end
    else if (ce)
    begin
      link_status <= status_next;
      tx_start    <= passthrough && (fill_words >= {3'h0, tx_wmark}); // [RULE6]
    end
  end

endmodule

`default_nettype wire

// ---- hdl/dpcpa_top.v ----
// data plane configuration registers and indirect mac/phy access engine
// assumes a word-indexed control register bus and mac cores on clk
//
// Behaviour
// [RULE1] settings change only while the data plane core is held in reset
// [RULE2] segment field 25:24 selects 64/128/256/512 byte egress segments, reset 00
// [RULE3] free space at or above hungry threshold reports hungry
// [RULE4] free space at or above starving threshold reports starving
// [RULE5] starving overrides hungry in every case
// [RULE6] pass-through transmit starts when fill reaches watermark bits 7:0
// [RULE7] command bit 31 written one starts a write of the low word
// [RULE8] command bit 31 written zero starts a read stored in data words
// [RULE9] bit 31 reads back the last written value
// [RULE10] bit 30 picks mac space at zero, phy space at one
// [RULE11] busy bit 29 sets on start, clears on completion
// [RULE12] mac accesses use the full ten-bit offset field 12:3
// [RULE13] phy accesses: upper five offset bits phy address, lower five register
// [RULE14] port select bits 2:0 choose the target network port
// [RULE15] high word holds upper 32 bits of latest statistics read, resets zero
// [RULE16] low word takes read results and supplies write data
// [RULE17] status bit 0 shows ethernet clock manager lock, read only
// [RULE18] error bits capture events and clear only where a one is written
// [RULE19] lock bits read one when unlocked, zero when locked
// [RULE20] control reset bits are active low
// [RULE21] processor reaches the bank over the control register bus at offset four
// [RULE22] software waits for busy to clear before the next access
`include "dpcpa_consts.vh"
`default_nettype none

module dpcpa_top #(
  parameter [15:0] REVISION_ID  = 16'h0000, // arbitrary value
  parameter        EIGHT_PORTS  = 1'b0,
  parameter        LOOPBACK     = 1'b0,
  parameter        ING_PASSTHRU = 1'b1,
  parameter        EGR_PASSTHRU = 1'b1
) (
  input  wire        clk,
  input  wire        reset,
  input  wire        ce,
  input  wire        reg_rd,
  input  wire        reg_wr,
  input  wire [2:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata,
  output reg         reg_ack,
  output reg         mac_req,
  output reg         mac_wr,
  output reg         mac_phy_sel,
  output reg  [2:0]  mac_port,
  output reg  [9:0]  mac_offset,
  output reg  [31:0] mac_wdata,
  input  wire        mac_ack,
  input  wire        mac_rd_is_stat,
  input  wire [63:0] mac_rdata,
  input  wire [87:0] ing_free_words,
  input  wire [87:0] ing_fill_words,
  output wire [15:0] ing_link_status,
  output wire [7:0]  ing_tx_start,
  output reg  [1:0]  egr_seg_code,
  output reg  [9:0]  egr_seg_bytes,
  input  wire [10:0] spi_err_evt,
  input  wire [7:0]  ing_underflow_evt,
  input  wire [7:0]  egr_overflow_evt,
  input  wire        rdclk_active,
  input  wire        tsclk_locked,
  input  wire        tdclk_locked,
  input  wire        rdclk_locked,
  input  wire        eth_clk_locked,
  output reg  [7:0]  block_reset_n,
  output reg  [7:0]  egr_fc_threshold,
  output reg         sink_enable,
  output reg         source_enable,
  output reg         phase_align_pulse,
  output reg         discard_on_error
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  reg [31:0] settings_reg;
  reg [31:0] command_reg;
  reg [31:0] low_word_reg;
  reg [31:0] high_word_reg;
  reg [31:0] control_reg;
  reg [31:0] sticky_reg;
  reg [31:0] sticky_next;
  reg [31:0] control_next;
  reg [31:0] rdata_next;
  reg        align_prev_reg;

  wire wr_hit_settings = reg_wr && (reg_addr == `DPCPA_OFF_SETTINGS);
  wire wr_hit_command  = reg_wr && (reg_addr == `DPCPA_OFF_COMMAND);
  wire wr_hit_low      = reg_wr && (reg_addr == `DPCPA_OFF_LOW_WORD);
  wire wr_hit_control  = reg_wr && (reg_addr == `DPCPA_OFF_CONTROL);
  wire wr_hit_status   = reg_wr && (reg_addr == `DPCPA_OFF_STATUS);
  wire busy            = command_reg[`DPCPA_CMD_BUSY];
  wire core_in_reset   = ~control_reg[`DPCPA_CTL_CORE_RST]; // [RULE20]
  wire start_access    = wr_hit_command && !busy;

  wire [31:0] sticky_set = {spi_err_evt, 4'h0, ing_underflow_evt, egr_overflow_evt, 1'b0};

  // clock manager bits read one while unlocked
  function [31:0] live_status;
    input [31:0] sticky;
    begin
      live_status     = sticky;
      live_status[20] = ~rdclk_active;   // [RULE19]
      live_status[19] = ~tsclk_locked;   // [RULE19]
      live_status[18] = ~tdclk_locked;   // [RULE19]
      live_status[17] = ~rdclk_locked;   // [RULE19]
      live_status[0]  = ~eth_clk_locked; // [RULE17] [RULE19]
    end
  endfunction

  // --------------------------------------------------------------------------
  // register bus slave: one-cycle ack, registered read data
  // --------------------------------------------------------------------------
  always @*
  begin
    if (reg_addr == `DPCPA_OFF_REVISION)
      rdata_next = {REVISION_ID, 12'h000, EGR_PASSTHRU[0], ING_PASSTHRU[0],
                    LOOPBACK[0], EIGHT_PORTS[0]};
    else if (reg_addr == `DPCPA_OFF_CONTROL)
      rdata_next = control_reg;
    else if (reg_addr == `DPCPA_OFF_STATUS)
      rdata_next = live_status(sticky_reg);
    else if (reg_addr == `DPCPA_OFF_SETTINGS)
      rdata_next = settings_reg;
    else if (reg_addr == `DPCPA_OFF_COMMAND)
      rdata_next = command_reg; // [RULE9]
    else if (reg_addr == `DPCPA_OFF_LOW_WORD)
      rdata_next = low_word_reg;
    else if (reg_addr == `DPCPA_OFF_HIGH_WORD)
      rdata_next = high_word_reg;
    else
      rdata_next = 32'h00000000;
  end

  // set wins over a write-one clear in the same cycle
  always @*
  begin
    sticky_next = sticky_reg;
    if (wr_hit_status)
      sticky_next = sticky_reg & ~reg_wdata; // [RULE18]
    sticky_next = sticky_next | sticky_set;
  end

  always @*
  begin
    control_next = control_reg;
    if (wr_hit_control)
    begin
      control_next = reg_wdata & `DPCPA_CTL_MASK;
      if (reg_wdata[`DPCPA_CTL_FC_HI:`DPCPA_CTL_FC_LO] > `DPCPA_CTL_FC_MAX)
        control_next[`DPCPA_CTL_FC_HI:`DPCPA_CTL_FC_LO] = `DPCPA_CTL_FC_MAX;
    end
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      reg_rdata      <= 32'h00000000;
      reg_ack        <= 1'b0;
      sticky_reg     <= `DPCPA_STS_RESET;
      control_reg    <= `DPCPA_CTL_RESET;
      settings_reg   <= `DPCPA_SET_RESET;
      align_prev_reg <= 1'b0;
    end
    else if (ce)
    begin
      reg_ack    <= reg_rd || reg_wr;
      reg_rdata  <= reg_rd ? rdata_next : 32'h00000000;
      sticky_reg <= sticky_next;
      control_reg <= control_next;
      align_prev_reg <= control_reg[`DPCPA_CTL_ALIGN];
      if (wr_hit_settings && core_in_reset)
        settings_reg <= reg_wdata & `DPCPA_SET_MASK; // [RULE1]
    end
  end

  // --------------------------------------------------------------------------
  // control outputs
  // --------------------------------------------------------------------------
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      block_reset_n     <= 8'h00;
      egr_fc_threshold  <= 8'h80;
      sink_enable       <= 1'b0;
      source_enable     <= 1'b0;
      phase_align_pulse <= 1'b0;
      discard_on_error  <= 1'b0;
      egr_seg_code      <= 2'h0;
      egr_seg_bytes     <= `DPCPA_SEG_BASE_BYTES;
    end
    else if (ce)
    begin
      block_reset_n     <= control_reg[7:0]; // [RULE20]
      egr_fc_threshold  <= control_reg[`DPCPA_CTL_FC_HI:`DPCPA_CTL_FC_LO];
      sink_enable       <= control_reg[`DPCPA_CTL_SINK_EN];
      source_enable     <= control_reg[`DPCPA_CTL_SRC_EN];
      phase_align_pulse <= control_reg[`DPCPA_CTL_ALIGN] && !align_prev_reg;
      discard_on_error  <= control_reg[`DPCPA_CTL_DISCARD];
      egr_seg_code      <= settings_reg[`DPCPA_SET_SEG_HI:`DPCPA_SET_SEG_LO]; // [RULE2]
      egr_seg_bytes     <= `DPCPA_SEG_BASE_BYTES <<
                           settings_reg[`DPCPA_SET_SEG_HI:`DPCPA_SET_SEG_LO]; // [RULE2]
    end
  end

  // --------------------------------------------------------------------------
  // indirect access engine
  // --------------------------------------------------------------------------
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      command_reg   <= `DPCPA_CMD_RESET;
      low_word_reg  <= `DPCPA_WORD_RESET;
      high_word_reg <= `DPCPA_WORD_RESET;
      mac_req       <= 1'b0;
      mac_wr        <= 1'b0;
      mac_phy_sel   <= 1'b0;
      mac_port      <= 3'h0;
      mac_offset    <= 10'h000;
      mac_wdata     <= 32'h00000000;
    end
    else if (ce)
    begin
      if (start_access)
      begin
        command_reg <= {reg_wdata[`DPCPA_CMD_DIR], reg_wdata[`DPCPA_CMD_PHY], 1'b1, 16'h0000,
                        reg_wdata[`DPCPA_CMD_OFF_HI:`DPCPA_CMD_OFF_LO],
                        reg_wdata[`DPCPA_CMD_PORT_HI:`DPCPA_CMD_PORT_LO]}; // [RULE9] [RULE11]
        mac_req     <= 1'b1;
        mac_wr      <= reg_wdata[`DPCPA_CMD_DIR]; // [RULE7] [RULE8]
        mac_phy_sel <= reg_wdata[`DPCPA_CMD_PHY]; // [RULE10]
        mac_offset  <= reg_wdata[`DPCPA_CMD_OFF_HI:`DPCPA_CMD_OFF_LO]; // [RULE12] [RULE13]
        mac_port    <= reg_wdata[`DPCPA_CMD_PORT_HI:`DPCPA_CMD_PORT_LO]; // [RULE14]
        mac_wdata   <= low_word_reg; // [RULE7] [RULE16]
      end
      else if (mac_req && mac_ack)
      begin
        mac_req                   <= 1'b0;
        command_reg[`DPCPA_CMD_BUSY] <= 1'b0; // [RULE11]
        if (!mac_wr)
        begin
          low_word_reg <= mac_rdata[31:0]; // [RULE8] [RULE16]
          if (mac_rd_is_stat)
            high_word_reg <= mac_rdata[63:32]; // [RULE15]
        end
      end
      else if (wr_hit_low && !busy)
        low_word_reg <= reg_wdata; // [RULE16]
    end
  end

  // --------------------------------------------------------------------------
  // per-port ingress status
  // --------------------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < 8; p = p + 1)
    begin : g_port
      dpcpa_port_status u_status (
        .clk         (clk),
        .reset       (reset),
        .ce          (ce),
        .free_words  (ing_free_words[p*11 +: 11]),
        .fill_words  (ing_fill_words[p*11 +: 11]),
        .hungry_thr  (settings_reg[`DPCPA_SET_HUNGRY_HI:`DPCPA_SET_HUNGRY_LO]),
        .starve_thr  (settings_reg[`DPCPA_SET_STARVE_HI:`DPCPA_SET_STARVE_LO]),
        .tx_wmark    (settings_reg[`DPCPA_SET_WMARK_HI:`DPCPA_SET_WMARK_LO]),
        .passthrough (ING_PASSTHRU[0]),
        .link_status (ing_link_status[p*2 +: 2]),
        .tx_start    (ing_tx_start[p])
      );
    end
  endgenerate

endmodule

`default_nettype wire

// ---- sim/dpcpa_mac_model.sv ----
// behavioural mac/phy register port on the far side of the indirect access engine
// assumes requests are held until the acknowledge edge, single clock domain
`default_nettype none

module dpcpa_mac_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [3:0]  dly,
  input  wire logic        mac_req,
  input  wire logic        mac_wr,
  input  wire logic        mac_phy_sel,
  input  wire logic [2:0]  mac_port,
  input  wire logic [9:0]  mac_offset,
  input  wire logic [31:0] mac_wdata,
  output var  logic        mac_ack,
  output var  logic        mac_rd_is_stat,
  output var  logic [63:0] mac_rdata,
  output var  logic [45:0] wr_log
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0]  cnt;
  logic [31:0] lo;

  // answer word is built from the address so the bench can predict it
  assign lo = {18'h0, mac_phy_sel, mac_port, mac_offset};

  always @(posedge clk or posedge reset)
    if (reset)
    begin
      mac_ack        <= 1'b0;
      mac_rd_is_stat <= 1'b0;
      mac_rdata      <= 64'h0;
      wr_log         <= 46'h0;
      cnt            <= 4'h0;
    end
    else if (mac_req && !mac_ack && cnt == dly)
    begin
      mac_ack        <= 1'b1;
      mac_rd_is_stat <= mac_offset[9];
      mac_rdata      <= {~lo, lo};
      if (mac_wr)
        wr_log <= {mac_phy_sel, mac_port, mac_offset, mac_wdata};
    end
    else
    begin
      mac_ack   <= 1'b0;
      cnt       <= (mac_req && !mac_ack) ? cnt + 4'h1 : 4'h0;
      // released data lines invert the last answer every cycle instead of holding it
      mac_rdata <= ~mac_rdata;
    end
endmodule

`default_nettype wire

// ---- sim/dpcpa_monitor.sv ----
// concurrent checks on the ports of the register bank top
// assumes bind into dpcpa_top, one clock, asynchronous active high reset
`default_nettype none

module dpcpa_monitor (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        ce,
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  input wire logic [2:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_ack,
  input wire logic        mac_req,
  input wire logic        mac_ack,
  input wire logic        mac_wr,
  input wire logic        mac_phy_sel,
  input wire logic [2:0]  mac_port,
  input wire logic [9:0]  mac_offset,
  input wire logic [1:0]  egr_seg_code,
  input wire logic [9:0]  egr_seg_bytes
);
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (reset);

  logic cmd_go;
  // command write accepted only while the engine is idle
  assign cmd_go = ce && reg_wr && reg_addr == 3'h4 && !mac_req;

  property p_ack;
    reg_ack |-> $past(ce && (reg_rd || reg_wr));
  endproperty
  a_ack: assert property (p_ack) else $error("ack without a strobe");
  property p_start_wr;
    cmd_go && reg_wdata[31] |=> mac_req && mac_wr;
  endproperty
  a_start_wr: assert property (p_start_wr) else $error("write not started");
  property p_start_rd;
    cmd_go && !reg_wdata[31] |=> mac_req && !mac_wr;
  endproperty
  a_start_rd: assert property (p_start_rd) else $error("read not started");
  property p_space;
    cmd_go |=> mac_phy_sel == $past(reg_wdata[30]);
  endproperty
  a_space: assert property (p_space) else $error("wrong register space");
  property p_offset;
    cmd_go |=> mac_offset == $past(reg_wdata[12:3]);
  endproperty
  a_offset: assert property (p_offset) else $error("wrong offset");
  property p_port;
    cmd_go |=> mac_port == $past(reg_wdata[2:0]);
  endproperty
  a_port: assert property (p_port) else $error("wrong port");
  property p_hold;
    mac_req && !(ce && mac_ack) |=> mac_req && $stable(mac_offset) && $stable(mac_port);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped early");
  property p_done;
    ce && mac_req && mac_ack |=> !mac_req;
  endproperty
  a_done: assert property (p_done) else $error("request outlives ack");
  property p_seg;
    egr_seg_bytes == (10'h040 << egr_seg_code);
  endproperty
  a_seg: assert property (p_seg) else $error("segment size mismatch");
endmodule

bind dpcpa_top dpcpa_monitor mon_u (.clk(clk), .reset(reset), .ce(ce), .reg_rd(reg_rd),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack),
  .mac_req(mac_req), .mac_ack(mac_ack), .mac_wr(mac_wr), .mac_phy_sel(mac_phy_sel),
  .mac_port(mac_port), .mac_offset(mac_offset), .egr_seg_code(egr_seg_code),
  .egr_seg_bytes(egr_seg_bytes));

`default_nettype wire

// ---- sim/dpcpa_tb_top.sv ----
// self-checking bench for the data plane register bank and access engine
// assumes dpcpa_top, dpcpa_mac_model and the bound monitor are compiled
`default_nettype none

module dpcpa_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk, reset = 1'b1, reg_rd = 1'b0, reg_wr = 1'b0, reg_ack;
  logic        mac_req, mac_wr, mac_phy_sel, mac_ack, mac_rd_is_stat;
  logic [2:0]  reg_addr = 3'h0, mac_port;
  logic [9:0]  mac_offset, seg_bytes;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, mac_wdata, v;
  logic [63:0] mac_rdata;
  logic [87:0] free_w = 88'h0, fill_w = 88'h0;
  logic [15:0] lst;
  logic [7:0]  txs, brn, und_evt = 8'h0;
  logic [4:0]  lk = 5'h1f;
  logic [3:0]  dly = 4'h6;
  logic [1:0]  seg_code;
  logic [7:0]  fct;
  logic        snk, src, pap, dis;
  int          pulses = 0;
  logic [45:0] wr_log;
  int          err_count = 0;
  int          checks = 0;

  dpcpa_top dut_u (.clk(clk), .reset(reset), .ce(1'b1), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .mac_req(mac_req), .mac_wr(mac_wr), .mac_phy_sel(mac_phy_sel), .mac_port(mac_port),
    .mac_offset(mac_offset), .mac_wdata(mac_wdata), .mac_ack(mac_ack),
    .mac_rd_is_stat(mac_rd_is_stat), .mac_rdata(mac_rdata), .ing_free_words(free_w),
    .ing_fill_words(fill_w), .ing_link_status(lst), .ing_tx_start(txs),
    .egr_seg_code(seg_code), .egr_seg_bytes(seg_bytes), .spi_err_evt(11'h0),
    .ing_underflow_evt(und_evt), .egr_overflow_evt(8'h0), .rdclk_active(lk[4]),
    .tsclk_locked(lk[3]), .tdclk_locked(lk[2]), .rdclk_locked(lk[1]),
    .eth_clk_locked(lk[0]), .block_reset_n(brn), .egr_fc_threshold(fct), .sink_enable(snk),
    .source_enable(src), .phase_align_pulse(pap), .discard_on_error(dis));

  // counts one-cycle alignment pulses
  always @(posedge clk)
    if (pap === 1'b1)
      pulses++;

  dpcpa_mac_model mac_u (.clk(clk), .reset(reset), .dly(dly), .mac_req(mac_req),
    .mac_wr(mac_wr), .mac_phy_sel(mac_phy_sel), .mac_port(mac_port),
    .mac_offset(mac_offset), .mac_wdata(mac_wdata), .mac_ack(mac_ack),
    .mac_rd_is_stat(mac_rd_is_stat), .mac_rdata(mac_rdata), .wr_log(wr_log));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ------------------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic acc(input logic w, input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= w;
    reg_rd    <= !w;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_ack, 1'b1);
    v = reg_rdata;
  endtask

  task automatic rdc(input logic [2:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(v, e);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    v = 32'hffffffff;
    while (v[29] !== 1'b0 && n < 40)
    begin
      acc(1'b0, 3'h4, 32'h0);
      n++;
    end
    chk(n < 40, 1'b1);
  endtask

  task automatic complete_run;
    $display("checks=%0d errors=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ------------------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rdc(3'h3, 32'h0080f00a);
    rdc(3'h4, 32'h0);
    rdc(3'h5, 32'h0);
    rdc(3'h6, 32'h0);
    rdc(3'h7, 32'h0);
    rdc(3'h2, 32'h0);
    chk(lst, 16'haaaa);
    for (int c = 0; c < 4; c++)
    begin
      acc(1'b1, 3'h3, {6'h0, c[1:0], 24'h102005});
      repeat (2) @(posedge clk);
      chk(seg_bytes, 10'h040 << c);
      chk(seg_code, c[1:0]);
    end
    @(posedge clk);
    free_w <= {55'h0, 11'h00f, 11'h010, 11'h020};
    fill_w <= {66'h0, 11'h004, 11'h005};
    repeat (3) @(posedge clk);
    chk(lst, 16'haaa4);
    chk(txs, 8'h01);
    acc(1'b1, 3'h3, 32'h00302005);
    free_w <= {55'h0, 11'h00f, 11'h035, 11'h02f};
    repeat (3) @(posedge clk);
    chk(lst, 16'haaa0);
    acc(1'b1, 3'h1, 32'h00ff0f04);
    acc(1'b1, 3'h3, 32'h0);
    chk(brn, 8'h04);
    chk(fct, 8'hbf);
    chk({snk, src, dis}, 3'h7);
    chk(pulses, 1);
    rdc(3'h1, 32'h00bf0f04);
    rdc(3'h3, 32'h00302005);
    acc(1'b1, 3'h5, 32'h1234abcd);
    acc(1'b1, 3'h4, 32'h80001ffd);
    rdc(3'h4, 32'ha0001ffd);
    acc(1'b1, 3'h4, 32'h0);
    wait_idle;
    rdc(3'h4, 32'h80001ffd);
    chk(wr_log, {1'b0, 3'h5, 10'h3ff, 32'h1234abcd});
    dly <= 4'h0;
    acc(1'b1, 3'h4, 32'h00001000);
    wait_idle;
    rdc(3'h5, 32'h00000200);
    rdc(3'h6, 32'hfffffdff);
    acc(1'b1, 3'h4, 32'h4000002f);
    wait_idle;
    rdc(3'h5, 32'h00003c05);
    rdc(3'h6, 32'hfffffdff);
    @(posedge clk);
    und_evt <= 8'h81;
    @(posedge clk);
    und_evt <= 8'h00;
    rdc(3'h2, 32'h00010200);
    acc(1'b1, 3'h2, 32'h00000200);
    rdc(3'h2, 32'h00010000);
    @(posedge clk);
    lk <= 5'h1e;
    rdc(3'h2, 32'h00010001);
    @(posedge clk);
    lk <= 5'h0f;
    rdc(3'h2, 32'h00110000);
    complete_run;
  end

  initial
  begin
    #20000;
    err_count++;
    complete_run;
  end
endmodule

`default_nettype wire
